// File: src/pfp_serial_frame_port.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_serial_frame_port #(
    parameter int STORE_CYCLES = pfp_pkg::STORE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    output logic ready,
    output logic ready_oe,
    output logic [pfp_pkg::DATA_W-1:0] wiper_setting_register,
    output logic shutdown
);
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
    logic din_s;
    logic frame_ok;
    logic [3:0] cmd;
    logic [pfp_pkg::DATA_W-1:0] data;
    pfp_pkg::pfp_state_t st;
    pfp_pkg::pfp_state_t next_st;

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // pins: bit 0 serial clock, bit 1 select, bit 2 data
    pfp_pin_sync #(
        .W(3)
    ) u_pins (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .pin({serial_in, frame_sel_n, serial_clk}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign sclk_fall = pin_fall[0];
    assign sel_fall = pin_fall[1];
    assign sel_rise = pin_rise[1];
    assign din_s = pin_level[2];

    // frame qualifies only on whole multiples of sixteen bits
    assign frame_ok = st.active && sel_rise && st.full && (st.cnt == 4'h0);
    assign cmd = st.shift[pfp_pkg::CMD_MSB:pfp_pkg::CMD_LSB];
    assign data = st.shift[pfp_pkg::DATA_W-1:0];

    always_comb begin
        logic [4:0] idx;
        logic zero_lead;
        idx = 5'(st.used - 5'h01);
        zero_lead = (st.shift[pfp_pkg::LEAD_MSB:pfp_pkg::LEAD_LSB] == 2'h0);
        next_st = st;
        // ready stays low until the busy timer runs out
        if (st.busy) begin
            if (st.timer == '0) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.timer = st.timer - 21'h000001;
            end
        end
        // count restarts at each select fall
        if (sel_fall) begin
            next_st.active = 1'b1;
            next_st.full = 1'b0;
            next_st.cnt = 4'h0;
        end else if (st.active && sclk_fall) begin
            // shift on the falling clock, msb arrives first
            next_st.shift = {st.shift[pfp_pkg::FRAME_BITS-2:0], din_s};
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'hF) begin
                next_st.full = 1'b1;
            end
        end
        if (sel_rise) begin
            next_st.active = 1'b0;
        end
        // act at select rise; partial frames fall through untouched
        // frames without two leading zeros are dropped; locked while busy
        if (frame_ok && zero_lead && !st.busy) begin
            case (cmd)
                pfp_pkg::CMD_WR_WIPER: begin
                    if (st.ctrl[pfp_pkg::CTRL_WIPER_EN_BIT]) begin
                        next_st.wiper = data;
                    end
                end
                pfp_pkg::CMD_RD_WIPER: begin
                    next_st.shift = {pfp_pkg::PAD_W'(0), st.wiper};
                end
                pfp_pkg::CMD_STORE: begin
                    if (st.ctrl[pfp_pkg::CTRL_STORE_EN_BIT] &&
                            st.used < pfp_pkg::MEM_SLOTS_V) begin
                        next_st.mem[st.used] = st.wiper;
                        next_st.used = st.used + 5'h01;
                    end
                end
                pfp_pkg::CMD_REFRESH: begin
                    next_st.wiper = (st.used == 5'h00) ? pfp_pkg::WIPER_MIDSCALE : st.mem[idx];
                end
                pfp_pkg::CMD_RD_MEM: begin
                    // addresses past the last slot return the used-slot count
                    if (data[pfp_pkg::ADDR_W-1:0] < pfp_pkg::MEM_SLOTS_V) begin
                        next_st.shift = {pfp_pkg::PAD_W'(0), st.mem[data[pfp_pkg::ADDR_W-1:0]]};
                    end else begin
                        next_st.shift = {11'h000, st.used};
                    end
                end
                pfp_pkg::CMD_WR_CTRL: begin
                    next_st.ctrl = data[pfp_pkg::CTRL_W-1:0];
                end
                pfp_pkg::CMD_RD_CTRL: begin
                    next_st.shift = {12'h000, st.ctrl};
                end
                pfp_pkg::CMD_SHUTDOWN: begin
                    next_st.shdn = data[0];
                end
                default: begin
                    next_st.shdn = st.shdn;
                end
            endcase
            // every defined command but a no-op starts a busy window; codes above 8 do not
            if (cmd != pfp_pkg::CMD_NOP && cmd <= pfp_pkg::CMD_SHUTDOWN) begin
                next_st.busy = 1'b1;
                next_st.timer = (cmd == pfp_pkg::CMD_STORE) ?
                    21'(STORE_CYCLES - 1) : pfp_pkg::OP_BUSY_LOAD;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '{active: 1'b0, full: 1'b0, cnt: '0, shift: '0,
                    wiper: pfp_pkg::WIPER_MIDSCALE, ctrl: pfp_pkg::CTRL_RESET,
                    shdn: 1'b0, used: '0, mem: '0, busy: 1'b0, timer: '0};
        end else begin
            st <= next_st;
        end
    end

    // open drain: level fixed low, only the enable moves
    assign serial_out = 1'b0;
    // msb of the shifter is driven out during a frame
    assign serial_out_oe = st.active && !st.shift[pfp_pkg::FRAME_BITS-1];
    // ready pulled low while busy, released high otherwise
    assign ready = 1'b0;
    assign ready_oe = st.busy;
    assign wiper_setting_register = st.wiper;
    assign shutdown = st.shdn;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_wr_start;
        frame_ok && !st.busy && st.shift[15:14] == 2'h0 && cmd == pfp_pkg::CMD_WR_WIPER;
    endsequence

    sequence s_busy_window;
        ready_oe [*4] ##1 !ready_oe;
    endsequence

    a_shift_on_fall: assert property (
        (st.active && sclk_fall && !sel_fall && !frame_ok) |=>
            st.shift == {$past(st.shift[14:0]), $past(din_s)})
        else $error("shifter did not take the data bit");
    a_idle_no_shift: assert property (
        (!st.active && !sel_fall) |=> $stable(st.shift) && $stable(st.cnt))
        else $error("shifter moved outside a frame");
    a_count_restart: assert property (
        sel_fall |=> st.active && st.cnt == 4'h0 && !st.full)
        else $error("bit count not restarted");
    a_write_update: assert property (
        (s_wr_start and st.ctrl[1]) |=> st.wiper == $past(data))
        else $error("wiper not updated at frame end");
    a_abort_keeps: assert property (
        (sel_rise && !(st.full && st.cnt == 4'h0)) |=>
            $stable(st.wiper) && $stable(st.ctrl) && $stable(st.shdn))
        else $error("aborted frame changed a register");
    a_sdo_released: assert property (
        !st.active |-> !serial_out_oe)
        else $error("serial output driven outside a frame");
    a_sdo_follows: assert property (
        (st.active && sclk_fall && !sel_rise && !sel_fall) |=>
            serial_out_oe == !$past(st.shift[14]))
        else $error("serial output does not follow the shifter");
    a_ready_window: assert property (
        s_wr_start |=> s_busy_window)
        else $error("ready low window is not four cycles");
    a_read_loads: assert property (
        (frame_ok && !st.busy && st.shift[15:14] == 2'h0 && cmd == pfp_pkg::CMD_RD_WIPER)
            |=> st.shift == {6'h00, $past(st.wiper)})
        else $error("readback not loaded for next frame");
    a_lead_zero: assert property (
        (frame_ok && st.shift[15:14] != 2'h0) |=> $stable(st.wiper) && $stable(st.ctrl))
        else $error("frame without leading zeros was acted on");
endmodule : pfp_serial_frame_port
`default_nettype wire

// File: src/pfp_pkg.sv
package pfp_pkg;
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 4;
    localparam int LEAD_MSB = 15;
    localparam int LEAD_LSB = 14;
    localparam int CMD_MSB = 13;
    localparam int CMD_LSB = 10;
    localparam int DATA_W = 10;
    localparam int CTRL_W = 4;
    localparam int ADDR_W = 5;
    localparam int PAD_W = FRAME_BITS - DATA_W;
    // command codes
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_WIPER = 4'h1;
    localparam logic [3:0] CMD_RD_WIPER = 4'h2;
    localparam logic [3:0] CMD_STORE = 4'h3;
    localparam logic [3:0] CMD_REFRESH = 4'h4;
    localparam logic [3:0] CMD_RD_MEM = 4'h5;
    localparam logic [3:0] CMD_WR_CTRL = 4'h6;
    localparam logic [3:0] CMD_RD_CTRL = 4'h7;
    localparam logic [3:0] CMD_SHUTDOWN = 4'h8;
    // control register bits
    localparam int CTRL_STORE_EN_BIT = 0;
    localparam int CTRL_WIPER_EN_BIT = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // wiper memory
    localparam int MEM_SLOTS = 20;
    localparam logic [4:0] MEM_SLOTS_V = 5'h14;
    localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int STORE_TIME_US = 6000;
    localparam int STORE_CYCLES = STORE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int OP_BUSY_CYCLES = 4;
    localparam int TIMER_W = 21;
    localparam logic [20:0] OP_BUSY_LOAD = 21'(OP_BUSY_CYCLES - 1);
    // whole state of the frame port
    typedef struct packed {
        logic active;
        logic full;
        logic [CNT_W-1:0] cnt;
        logic [FRAME_BITS-1:0] shift;
        logic [DATA_W-1:0] wiper;
        logic [CTRL_W-1:0] ctrl;
        logic shdn;
        logic [4:0] used;
        logic [MEM_SLOTS-1:0][DATA_W-1:0] mem;
        logic busy;
        logic [TIMER_W-1:0] timer;
    } pfp_state_t;
endpackage : pfp_pkg

// File: src/pfp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_pin_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } pfp_sync_t;

    pfp_sync_t s;
    pfp_sync_t next_s;

    // two flops, then a third copy for edges; meta feeds only sync
    always_comb begin
        next_s.meta = pin;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '1; // select and clock idle high, so no false edge after reset
        end else begin
            s <= next_s;
        end
    end

    // per-pin edge detection on the settled copies
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign level[i] = s.sync[i];
        assign rise[i] = s.sync[i] & ~s.prev[i];
        assign fall[i] = ~s.sync[i] & s.prev[i];
    end
endmodule : pfp_pin_sync
`default_nettype wire

// File: bench/pfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfp_host_model (
    input wire logic core_clk,
    input wire logic sdo_line,
    output logic frame_sel_n,
    output logic serial_clk,
    output logic serial_in
);
    // serial clock idles high and stands still outside frames
    initial begin
        frame_sel_n = 1'b1;
        serial_clk = 1'b1;
        serial_in = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    // one frame of n bits, half period of four core cycles
    task automatic xfer(input logic [31:0] word, input int n, output logic [31:0] seen);
        seen = '0;
        frame_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            // top bit first, data steady 16 ns around the fall
            serial_in = word[i];
            idle(4);
            seen = {seen[30:0], sdo_line};
            // 32 ns period, far below the ceiling
            serial_clk = 1'b0;
            idle(4);
            serial_clk = 1'b1;
        end
        idle(4);
        frame_sel_n = 1'b1;
        serial_in = ~serial_in; // released: never leave a stale bit
        idle(4);
    endtask : xfer
endmodule : pfp_host_model
`default_nettype wire

// File: bench/test_pot_serial_frame_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_pot_serial_frame_port;
    logic core_clk, rst_n, frame_sel_n, serial_clk, serial_in;
    logic serial_out, serial_out_oe, ready, ready_oe, shutdown;
    logic [pfp_pkg::DATA_W-1:0] wiper_setting_register;
    logic sdo_line, ready_line;
    logic [31:0] seen;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // open-drain lines with pull-ups
    assign sdo_line = serial_out_oe ? serial_out : 1'b1;
    assign ready_line = ready_oe ? ready : 1'b1;
    pfp_serial_frame_port #(.STORE_CYCLES(20)) pfp_serial_frame_port_i (
        .core_clk(core_clk), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .ready(ready), .ready_oe(ready_oe),
        .wiper_setting_register(wiper_setting_register), .shutdown(shutdown));
    pfp_host_model pfp_host_model_i (
        .core_clk(core_clk), .sdo_line(sdo_line), .frame_sel_n(frame_sel_n),
        .serial_clk(serial_clk), .serial_in(serial_in));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // wait out the busy window, bounded
    task automatic send(input logic [15:0] w);
        int n;
        n = 0;
        pfp_host_model_i.xfer({16'h0000, w}, 16, seen);
        pfp_host_model_i.idle(8);
        while (ready_oe !== 1'b0 && n < 400) begin
            pfp_host_model_i.idle(1);
            n++;
        end
        check("ready", 16'h0001, 16'(ready_line));
    endtask : send
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic t_reset;
        check("wiper", 16'h0200, 16'(wiper_setting_register));
        check("shutdown", 16'h0000, 16'(shutdown));
        check("sdo", 16'h0001, 16'(sdo_line));
        $display("test reset done");
    endtask : t_reset
    // enable wiper writes, then write and watch ready
    task automatic t_write;
        send(16'h1803);
        pfp_host_model_i.xfer(32'h0000_0555, 16, seen);
        pfp_host_model_i.idle(1);
        check("busy", 16'h0000, 16'(ready_line));
        check("wiper", 16'h0155, 16'(wiper_setting_register));
        // host waits out the busy window before the next frame
        pfp_host_model_i.idle(8);
        send(16'h0000);
        $display("test write done");
    endtask : t_write
    // 24-bit frame would write if acted on; it must drop, next counts from zero
    task automatic t_abort;
        pfp_host_model_i.xfer(32'h0000_0544, 24, seen);
        pfp_host_model_i.idle(10);
        check("abort", 16'h0155, 16'(wiper_setting_register));
        send(16'h0566);
        check("restart", 16'h0166, 16'(wiper_setting_register));
        $display("test abort done");
    endtask : t_abort
    // reads answer in the next frame on the open-drain line
    task automatic t_read;
        send(16'h0800);
        pfp_host_model_i.xfer(32'h0, 16, seen);
        check("rd wiper", 16'h0166, seen[15:0]);
        send(16'h1C00);
        pfp_host_model_i.xfer(32'h0, 16, seen);
        check("rd ctrl", 16'h0003, seen[15:0]);
        $display("test read done");
    endtask : t_read
    task automatic t_shut;
        send(16'h2001);
        check("shut on", 16'h0001, 16'(shutdown));
        send(16'h2000);
        check("shut off", 16'h0000, 16'(shutdown));
        $display("test shutdown done");
    endtask : t_shut
    // store, overwrite, refresh, then ask for the slot count
    task automatic t_mem;
        send(16'h0C00);
        send(16'h0577);
        send(16'h1000);
        check("refresh", 16'h0166, 16'(wiper_setting_register));
        send(16'h141F);
        pfp_host_model_i.xfer(32'h0, 16, seen);
        check("used", 16'h0001, seen[15:0]);
        send(16'h1400);
        pfp_host_model_i.xfer(32'h0, 16, seen);
        check("slot 0", 16'h0166, seen[15:0]);
        $display("test memory done");
    endtask : t_mem
    // 32-bit frame acts on last word, first word passes through
    task automatic t_chain;
        pfp_host_model_i.xfer(32'h0511_0522, 32, seen);
        pfp_host_model_i.idle(12);
        check("chain wiper", 16'h0122, 16'(wiper_setting_register));
        check("chain out", 16'h0511, seen[15:0]);
        send(16'h8533);
        check("lead bits", 16'h0122, 16'(wiper_setting_register));
        $display("test chain done");
    endtask : t_chain
    // mid-run reset: registers back to reset values, wiper writes locked again
    task automatic t_rerun;
        rst_n = 1'b0;
        pfp_host_model_i.idle(16);
        rst_n = 1'b1;
        pfp_host_model_i.idle(8);
        check("rerun wiper", 16'h0200, 16'(wiper_setting_register));
        check("rerun ready", 16'h0001, 16'(ready_line));
        check("rerun sdo", 16'h0001, 16'(sdo_line));
        send(16'h0555);
        check("write locked", 16'h0200, 16'(wiper_setting_register));
        $display("test mid-run reset done");
    endtask : t_rerun
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        t_reset();
        t_write();
        t_abort();
        t_read();
        t_shut();
        t_mem();
        t_chain();
        t_rerun();
        give_verdict();
    end
endmodule : test_pot_serial_frame_port
`default_nettype wire
